//--- hw/acs_sequencer.sv
// How it works
// - Start from write, pin, timer2 or timer0.
// - Mode 00: one channel four times, four registers.
// - Mode 01: one channel repeatedly, one register updated.
// - Mode 10: four channels once, four registers.
// - Mode 11: four channels continuously, registers refreshed.
// - Sequence starts at chosen channel, wraps 3 to 0.
// - New start aborts running conversion, restarts.
// - Settings apply only at next accepted start.
// - Converter clock is system clock over 8..64.
// - Interrupt after first or fourth conversion.
// - Enable bit powers converter down or up.
// - Auto-zero during sampling, before conversion.
// - Result is 8 bits, upper then lower nibble.
// - Control register sits at bank 13 slot zero.
// - Bank 5 holds all four results.
// - Sixteen banks, bank select in slot seven everywhere.
// - Source field bits 9:8 picks start source.
// - Mode field bits 4:3 picks sequence mode.
// - Enable low blocks everything except enable writes and bank select access.
// - Flag bit 12 read-only, cleared by write; bits 11, 10.
module acs_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [acs_pkg::EXT_SLOT_W-1:0] ext_slot,
  input wire logic ext_wr,
  input wire logic ext_rd,
  input wire logic [acs_pkg::EXT_DATA_W-1:0] ext_wdata,
  output logic [acs_pkg::EXT_DATA_W-1:0] ext_rdata,
  output logic ext_hit,
  input wire logic external_trigger_pin,
  input wire logic timer2_zero,
  input wire logic timer0_zero,
  input wire logic [3:0] afe_coarse_code,
  input wire logic [3:0] afe_fine_code,
  output acs_pkg::acs_afe_s afe,
  output logic converter_power_on,
  output logic busy,
  output logic conversion_irq
);

  // Programmed and active (latched at start) settings.
  acs_pkg::acs_ctl_s ctl_q;
  acs_pkg::acs_ctl_s ctl_d;
  acs_pkg::acs_ctl_s act_q;
  logic [acs_pkg::BANK_W-1:0] bank_q;
  logic irq_flag_q;
  logic [acs_pkg::RES_W-1:0] result_q [acs_pkg::NUM_CH];

  acs_pkg::acs_state_e state_q;
  acs_pkg::acs_state_e state_d;
  logic [6:0] div_cnt_q;
  logic [1:0] sample_cnt_q;
  logic [1:0] chan_q;
  logic [2:0] conv_cnt_q;
  logic [3:0] coarse_q;

  logic trig_meta_q;
  logic trig_sync_q;
  logic trig_prev_q;

  logic [acs_pkg::EXT_DATA_W-1:0] rdata_q;
  logic [acs_pkg::EXT_DATA_W-1:0] rd_mux;

  // Address decode.
  wire bank_wr = ext_wr && (ext_slot == acs_pkg::BANK_SELECT_SLOT);
  wire ctl_sel = (bank_q == acs_pkg::BANK_CTRL) && (ext_slot == acs_pkg::SLOT_ZERO);
  wire ctl_wr = ext_wr && ctl_sel;
  wire in_bank5 = (bank_q == acs_pkg::BANK_ALL_RESULTS);
  wire low_bank = (bank_q <= acs_pkg::BANK_CH3_ONLY);
  wire slot6 = (ext_slot == acs_pkg::SLOT_SIX);

  // Result slot mapping: bank 5 sees all four, banks 0-3 one each, bank 4 none, others channel 0.
  wire res1_b5 = in_bank5 && (ext_slot == acs_pkg::SLOT_ZERO);
  wire res2_b5 = in_bank5 && (ext_slot == acs_pkg::SLOT_ONE);
  wire res3_b5 = in_bank5 && (ext_slot == acs_pkg::SLOT_TWO);
  wire res_slot6 = slot6 && (bank_q != 4'h4);
  wire [1:0] res6_idx = low_bank ? bank_q[1:0] : 2'h0;
  wire res_sel = res1_b5 || res2_b5 || res3_b5 || res_slot6;
  wire [1:0] res_idx = res1_b5 ? 2'h1 :
                       res2_b5 ? 2'h2 :
                       res3_b5 ? 2'h3 : res6_idx;

  assign ext_hit = ctl_sel || res_sel || (ext_slot == acs_pkg::BANK_SELECT_SLOT);

  // Enable-low writes only touch the enable bit.
  wire wr_enable = ext_wdata[acs_pkg::CONVERTER_ENABLE_BIT];
  always_comb begin
    ctl_d = ctl_q;
    if (ctl_wr) begin
      if (ctl_q.enable) begin
        ctl_d.irq_timing = ext_wdata[acs_pkg::IRQ_TIMING_SELECT];
        ctl_d.irq_enable = ext_wdata[acs_pkg::IRQ_ENABLE_BIT];
        ctl_d.source = acs_pkg::acs_src_e'(ext_wdata[acs_pkg::START_SOURCE_SEL_HI:
                                                     acs_pkg::START_SOURCE_SEL_LO]);
        ctl_d.prescale = ext_wdata[acs_pkg::PRESCALE_HI:acs_pkg::PRESCALE_LO];
        ctl_d.mode = acs_pkg::acs_mode_e'(ext_wdata[acs_pkg::MODE_HI:acs_pkg::MODE_LO]);
        ctl_d.channel = ext_wdata[acs_pkg::CHANNEL_SEL_HI:acs_pkg::CHANNEL_SEL_LO];
      end
      ctl_d.enable = wr_enable;
    end
  end

  // External trigger crosses in through two flops before edge detection.
  wire trig_rise = trig_sync_q && !trig_prev_q;

  // A software start uses the settings of the write that carries it.
  wire sw_start = ctl_wr && ctl_q.enable && wr_enable && (ctl_d.source == acs_pkg::SRC_WRITE);
  logic src_hit;
  assign src_hit = (ctl_q.source == acs_pkg::SRC_TRIGGER_PIN) ? trig_rise :
                   (ctl_q.source == acs_pkg::SRC_TIMER2) ? timer2_zero :
                   (ctl_q.source == acs_pkg::SRC_TIMER0) ? timer0_zero : 1'b0;
  wire hw_start = ctl_q.enable && !ctl_wr && src_hit;
  wire start = sw_start || hw_start;

  // Converter clock tick: divide by (code + 1) * 8.
  wire [6:0] div_total = 7'((7'(act_q.prescale) + 7'h01) * acs_pkg::PRESCALE_STEP);
  wire tick = (state_q != acs_pkg::ST_IDLE) && (div_cnt_q == div_total - 7'h01);

  // Sequence decisions at the end of a conversion.
  wire four_ch = act_q.mode[1];
  wire last_of_four = (conv_cnt_q == acs_pkg::CONV_FOURTH);
  wire done = (state_q == acs_pkg::ST_FINE) && tick;
  wire continuous = (act_q.mode == acs_pkg::MODE_ONE_CH_CONT) ||
                    (act_q.mode == acs_pkg::MODE_FOUR_CH_CONT);
  wire seq_end = !continuous && last_of_four;
  wire [1:0] wr_idx = (act_q.mode == acs_pkg::MODE_ONE_CH_FOUR) ? conv_cnt_q[1:0] : chan_q;
  wire irq_point = act_q.irq_timing ? (conv_cnt_q == acs_pkg::CONV_FOURTH) :
                                      (conv_cnt_q == acs_pkg::CONV_FIRST);
  wire irq_set = done && act_q.irq_enable && irq_point;

  always_comb begin
    state_d = state_q;
    case (state_q)
      acs_pkg::ST_IDLE: begin
        state_d = acs_pkg::ST_IDLE;
      end
      acs_pkg::ST_SAMPLE: begin
        if (tick && (sample_cnt_q == acs_pkg::SAMPLE_TICKS - 2'h1)) begin
          state_d = acs_pkg::ST_COARSE;
        end
      end
      acs_pkg::ST_COARSE: begin
        if (tick) begin
          state_d = acs_pkg::ST_FINE;
        end
      end
      acs_pkg::ST_FINE: begin
        if (tick) begin
          state_d = seq_end ? acs_pkg::ST_IDLE : acs_pkg::ST_SAMPLE;
        end
      end
      default: begin
        state_d = acs_pkg::ST_IDLE;
      end
    endcase
    if (start) begin
      state_d = acs_pkg::ST_SAMPLE;
    end
    // A disabling write stops the sequence at its own edge, so busy never outlives the enable bit.
    if (!ctl_d.enable) begin
      state_d = acs_pkg::ST_IDLE;
    end
  end

  // Register read data: everything but the bank select reads zero while disabled.
  wire [acs_pkg::EXT_DATA_W-1:0] ctl_rd = {ctl_q.enable, 2'h0, irq_flag_q, ctl_q.irq_timing,
                                          ctl_q.irq_enable, ctl_q.source, ctl_q.prescale,
                                          ctl_q.mode, ctl_q.channel};
  always_comb begin
    rd_mux = '0;
    if (ext_slot == acs_pkg::BANK_SELECT_SLOT) begin
      rd_mux = {12'h000, bank_q};
    end else if (ctl_sel) begin
      rd_mux = ctl_q.enable ? ctl_rd : {ctl_q.enable, 15'h0000};
    end else if (res_sel && ctl_q.enable) begin
      rd_mux = {8'h00, result_q[res_idx]};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else if (ce) begin
      trig_meta_q <= external_trigger_pin;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= acs_pkg::CTL_RESET;
      bank_q <= acs_pkg::BANK_RESET;
      rdata_q <= '0;
    end else if (ce) begin
      ctl_q <= ctl_d;
      if (bank_wr) begin
        bank_q <= ext_wdata[acs_pkg::BANK_W-1:0];
      end
      if (ext_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Set wins over the clear that any control write makes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_flag_q <= 1'b0;
    end else if (ce) begin
      if (irq_set) begin
        irq_flag_q <= 1'b1;
      end else if (ctl_wr) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  // Active settings are frozen between accepted starts.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_q <= acs_pkg::CTL_RESET;
    end else if (ce && start) begin
      act_q <= ctl_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= acs_pkg::ST_IDLE;
      div_cnt_q <= 7'h00;
    end else if (ce) begin
      state_q <= state_d;
      if (start || tick || state_q == acs_pkg::ST_IDLE) begin
        div_cnt_q <= 7'h00;
      end else begin
        div_cnt_q <= div_cnt_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_cnt_q <= 2'h0;
      chan_q <= 2'h0;
      conv_cnt_q <= 3'h0;
      coarse_q <= 4'h0;
    end else if (ce) begin
      if (start) begin
        sample_cnt_q <= 2'h0;
        chan_q <= ctl_d.channel[1:0];
        conv_cnt_q <= 3'h0;
      end else if (tick) begin
        if (state_q == acs_pkg::ST_SAMPLE) begin
          sample_cnt_q <= sample_cnt_q + 2'h1;
        end
        if (state_q == acs_pkg::ST_COARSE) begin
          coarse_q <= afe_coarse_code;
        end
        if (done) begin
          sample_cnt_q <= 2'h0;
          if (four_ch) begin
            chan_q <= chan_q + 2'h1;
          end
          if (conv_cnt_q != acs_pkg::CONV_SATURATE) begin
            conv_cnt_q <= conv_cnt_q + 3'h1;
          end
        end
      end
    end
  end

  // Result registers, one per entry.
  for (genvar i = 0; i < acs_pkg::NUM_CH; i++) begin : g_res
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        result_q[i] <= 8'h00;
      end else if (ce && done && !start && wr_idx == 2'(i)) begin
        result_q[i] <= {coarse_q, afe_fine_code};
      end
    end
  end

  // Analog front-end controls; auto-zero runs for the whole sample phase.
  assign afe.channel = chan_q;
  assign afe.sample = (state_q == acs_pkg::ST_SAMPLE);
  assign afe.autozero = (state_q == acs_pkg::ST_SAMPLE);
  assign afe.coarse_strobe = (state_q == acs_pkg::ST_COARSE) && tick;
  assign afe.fine_strobe = done;

  assign ext_rdata = rdata_q;
  assign converter_power_on = ctl_q.enable;
  assign busy = (state_q != acs_pkg::ST_IDLE);
  assign conversion_irq = irq_flag_q;

endmodule

//--- hw/acs_pkg.sv
package acs_pkg;

  // EXT bus geometry.
  localparam int EXT_SLOT_W = 3;
  localparam int EXT_DATA_W = 16;
  localparam int BANK_W = 4;
  localparam int RES_W = 8;
  localparam int NUM_CH = 4;

  localparam logic [2:0] SLOT_ZERO = 3'h0;
  localparam logic [2:0] SLOT_ONE = 3'h1;
  localparam logic [2:0] SLOT_TWO = 3'h2;
  localparam logic [2:0] SLOT_SIX = 3'h6;
  localparam logic [2:0] BANK_SELECT_SLOT = 3'h7;

  localparam logic [3:0] BANK_CTRL = 4'hd;
  localparam logic [3:0] BANK_ALL_RESULTS = 4'h5;
  localparam logic [3:0] BANK_CH3_ONLY = 4'h3;
  localparam logic [3:0] BANK_RESET = 4'h0;

  // Field positions of the converter control register.
  localparam int CONVERTER_ENABLE_BIT = 15;
  localparam int CONVERSION_IRQ_FLAG = 12;
  localparam int IRQ_TIMING_SELECT = 11;
  localparam int IRQ_ENABLE_BIT = 10;
  localparam int START_SOURCE_SEL_HI = 9;
  localparam int START_SOURCE_SEL_LO = 8;
  localparam int PRESCALE_HI = 7;
  localparam int PRESCALE_LO = 5;
  localparam int MODE_HI = 4;
  localparam int MODE_LO = 3;
  localparam int CHANNEL_SEL_HI = 2;
  localparam int CHANNEL_SEL_LO = 0;

  // Converter clock divide is (code + 1) times this step: 8 up to 64.
  localparam logic [6:0] PRESCALE_STEP = 7'h08;

  // Converter clock periods spent sampling with auto-zero active.
  localparam logic [1:0] SAMPLE_TICKS = 2'h2;

  // Least conversion time that software must respect, and its cycle count at 100 MHz.
  localparam int CLK_PERIOD_PS = 10000;
  localparam int MIN_CONV_TIME_PS = 2000000;
  localparam int MIN_CONV_CYCLES = (MIN_CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Conversion counts at which the first- and fourth-conversion interrupts fire, and where the count saturates.
  localparam logic [2:0] CONV_FIRST = 3'h0;
  localparam logic [2:0] CONV_FOURTH = 3'h3;
  localparam logic [2:0] CONV_SATURATE = 3'h4;

  typedef enum logic [1:0] {
    SRC_WRITE = 2'b00,
    SRC_TRIGGER_PIN = 2'b01,
    SRC_TIMER2 = 2'b10,
    SRC_TIMER0 = 2'b11
  } acs_src_e;

  typedef enum logic [1:0] {
    MODE_ONE_CH_FOUR = 2'b00,
    MODE_ONE_CH_CONT = 2'b01,
    MODE_FOUR_CH_ONCE = 2'b10,
    MODE_FOUR_CH_CONT = 2'b11
  } acs_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_COARSE = 2'b10,
    ST_FINE = 2'b11
  } acs_state_e;

  typedef struct packed {
    logic enable;
    logic irq_timing;
    logic irq_enable;
    acs_src_e source;
    logic [2:0] prescale;
    acs_mode_e mode;
    logic [2:0] channel;
  } acs_ctl_s;

  localparam acs_ctl_s CTL_RESET = '{
    enable: 1'b0, irq_timing: 1'b0, irq_enable: 1'b0, source: SRC_WRITE,
    prescale: 3'h0, mode: MODE_ONE_CH_FOUR, channel: 3'h0};

  typedef struct packed {
    logic [1:0] channel;
    logic sample;
    logic autozero;
    logic coarse_strobe;
    logic fine_strobe;
  } acs_afe_s;

endpackage

//--- tb/acs_afe_model.sv
module acs_afe_model (
  input wire acs_pkg::acs_afe_s afe,
  output logic [3:0] coarse_code,
  output logic [3:0] fine_code
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] hi = {2'b01, afe.channel};
  wire [3:0] lo = {2'b11, ~afe.channel};
  // Codes hold only on the strobe tick; the inverse elsewhere exposes a mistimed sample.
  assign coarse_code = afe.coarse_strobe ? hi : ~hi;
  assign fine_code = afe.fine_strobe ? lo : ~lo;
endmodule

//--- tb/acs_sequencer_props.sv
module acs_sequencer_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] ext_slot,
  input wire logic ext_wr,
  input wire logic ext_rd,
  input wire logic [15:0] ext_wdata,
  input wire logic [15:0] ext_rdata,
  input wire logic ext_hit,
  input wire acs_pkg::acs_afe_s afe,
  input wire logic converter_power_on,
  input wire logic busy,
  input wire logic conversion_irq
);
  logic [3:0] bank_q;
  wire ctl_wr = ext_wr && ext_slot == 3'h0 && bank_q == acs_pkg::BANK_CTRL;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) bank_q <= 4'h0;
    else if (ext_wr && ext_slot == 3'h7) bank_q <= ext_wdata[3:0];
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_start;
    ctl_wr && converter_power_on && ext_wdata[15] && ext_wdata[9:8] == 2'h0
      |=> busy && afe.sample && afe.channel == $past(ext_wdata[1:0]);
  endproperty
  a_start: assert property (p_start) else $error("software start missed");
  property p_power;
    ctl_wr |=> converter_power_on == $past(ext_wdata[15]);
  endproperty
  a_power: assert property (p_power) else $error("enable bit not applied");
  property p_off;
    !converter_power_on |-> !busy;
  endproperty
  a_off: assert property (p_off) else $error("busy while disabled");
  property p_az;
    afe.sample |-> afe.autozero && !afe.coarse_strobe && !afe.fine_strobe;
  endproperty
  a_az: assert property (p_az) else $error("sampling without auto-zero");
  property p_samp;
    $rose(afe.sample) |-> afe.sample [*8];
  endproperty
  a_samp: assert property (p_samp) else $error("sampling too short");
  property p_fine;
    afe.coarse_strobe |-> ##[1:64] (afe.fine_strobe || ctl_wr || !converter_power_on);
  endproperty
  a_fine: assert property (p_fine) else $error("fine step missing");
  property p_irqclr;
    ctl_wr && !afe.fine_strobe |=> !conversion_irq;
  endproperty
  a_irqclr: assert property (p_irqclr) else $error("flag not cleared");
  property p_irqset;
    $rose(conversion_irq) |-> afe.fine_strobe || $past(afe.fine_strobe);
  endproperty
  a_irqset: assert property (p_irqset) else $error("flag set off a conversion");
  property p_hit;
    ext_slot == 3'h7 |-> ext_hit;
  endproperty
  a_hit: assert property (p_hit) else $error("bank select not mapped");
  property p_unm;
    ext_rd && !ext_hit |=> ext_rdata == 16'h0000;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  c_start: cover property ($rose(busy));
  c_irq: cover property ($rose(conversion_irq));
  c_fine: cover property (afe.fine_strobe);
endmodule
bind acs_sequencer acs_sequencer_props props (.clk(clk), .rst(rst), .ext_slot(ext_slot),
  .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
  .ext_hit(ext_hit), .afe(afe), .converter_power_on(converter_power_on), .busy(busy),
  .conversion_irq(conversion_irq));

//--- tb/acs_sequencer_tb.sv
module acs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] ctl; logic [31:0] res; int hold;} acs_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] slot = 3'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic pin = 1'b0;
  logic t2 = 1'b0;
  logic t0 = 1'b0;
  logic [3:0] cc;
  logic [3:0] fc;
  logic [15:0] rdata;
  logic hit, pwr, busy, irq;
  acs_pkg::acs_afe_s afe;
  int fail_count = 0;
  int n_checks = 0;
  // Result bytes follow the model: coarse {01,ch}, fine {11,~ch}.
  acs_row_s rows[4] = '{
  // Prescale code 6 is the smallest that keeps a conversion at 2 us or more at 100 MHz.
    '{16'h80d2, 32'h7c6d5e4f, 0},
    '{16'h80c1, 32'h5e5e5e5e, 0},
    '{16'h80cb, 32'h7c5e5e5e, 300},
    '{16'h80d8, 32'h7c6d5e4f, 1000}};
  always #5 clk = ~clk;
  acs_sequencer dut (.clk(clk), .rst(rst), .ce(1'b1), .ext_slot(slot), .ext_wr(wr_s),
    .ext_rd(rd_s), .ext_wdata(wdata), .ext_rdata(rdata), .ext_hit(hit),
    .external_trigger_pin(pin), .timer2_zero(t2), .timer0_zero(t0),
    .afe_coarse_code(cc), .afe_fine_code(fc), .afe(afe), .converter_power_on(pwr),
    .busy(busy), .conversion_irq(irq));
  acs_afe_model afe_m (.afe(afe), .coarse_code(cc), .fine_code(fc));
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    slot <= s;
    wr_s <= 1'b1;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, input logic [15:0] e);
    @(posedge clk);
    slot <= s;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic run_idle;
    int i;
    i = 0;
    @(posedge clk);
    #1;
    while (busy !== 1'b0) begin
      i++;
      if (i > 4000) begin
        check({15'h0000, busy}, 16'h0000);
        give_verdict();
      end
      @(posedge clk);
      #1;
    end
  endtask
  // Counts busy cycles from the start edge; a wrong divide shows as a wrong count.
  task automatic busy_len(input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    #1;
    while (busy === 1'b1 && n < 16'h0fff) begin
      n++;
      @(posedge clk);
      #1;
    end
    check(n, exp);
    if (n == 16'h0fff) begin
      give_verdict();
    end
  endtask
  task automatic res4(input logic [31:0] e);
    wr(3'h7, 16'h0005);
    rd(3'h6, {8'h00, e[7:0]});
    rd(3'h0, {8'h00, e[15:8]});
    rd(3'h1, {8'h00, e[23:16]});
    rd(3'h2, {8'h00, e[31:24]});
    wr(3'h7, 16'h000d);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    pin <= m[0];
    t2 <= m[1];
    t0 <= m[2];
    @(posedge clk);
    pin <= 1'b0;
    t2 <= 1'b0;
    t0 <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 check({13'h0000, pwr, busy, irq}, 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    rd(3'h7, 16'h0000);
    wr(3'h7, 16'h000d);
    rd(3'h0, 16'h0000);
    rd(3'h7, 16'h000d);
    $display("test reset done");
    // The first enabling write only sets the enable bit and starts nothing, so this just confirms idle.
    wr(3'h0, 16'h8000);
    run_idle();
    foreach (rows[i]) begin
      wr(3'h0, rows[i].ctl);
      if (rows[i].hold == 0) begin
        run_idle();
      end else begin
        repeat (rows[i].hold) @(posedge clk);
        #1 check({15'h0000, busy}, 16'h0001);
      end
      res4(rows[i].res);
    end
    $display("test modes done");
    for (int p = 0; p < 8; p++) begin
      wr(3'h0, 16'h8000 | (16'(p) << 5));
      busy_len(16'(128 * (p + 1)));
    end
    #1 check({15'h0000, irq}, 16'h0000);
    $display("test prescale done");
    for (int tm = 0; tm < 2; tm++) begin
      wr(3'h0, 16'h84c0 | (16'(tm) << 11));
      repeat (300) @(posedge clk);
      #1 check({15'h0000, irq}, 16'(1 - tm));
      run_idle();
      check({15'h0000, irq}, 16'h0001);
      rd(3'h0, 16'h94c0 | (16'(tm) << 11));
      wr(3'h0, 16'h8100);
      #1 check({15'h0000, irq}, 16'h0000);
    end
    $display("test irq done");
    wr(3'h0, 16'h80e0);
    repeat (10) @(posedge clk);
    wr(3'h0, 16'h80c2);
    busy_len(16'h0380);
    res4(32'h6d6d6d6d);
    $display("test abort done");
    for (int s = 1; s < 4; s++) begin
      wr(3'h0, 16'h80c3 | (16'(s) << 8));
      pulse(3'h7 & ~3'(1 << (s - 1)));
      #1 check({15'h0000, busy}, 16'h0000);
      pulse(3'(1 << (s - 1)));
      #1 check({15'h0000, busy}, 16'h0001);
      run_idle();
    end
    $display("test sources done");
    wr(3'h0, 16'h80c0);
    repeat (20) @(posedge clk);
    wr(3'h0, 16'h0000);
    #1 check({14'h0000, pwr, busy}, 16'h0000);
    wr(3'h0, 16'h0018);
    pulse(3'h7);
    #1 check({15'h0000, busy}, 16'h0000);
    rd(3'h0, 16'h0000);
    wr(3'h7, 16'h0005);
    rd(3'h6, 16'h0000);
    wr(3'h7, 16'h0004);
    rd(3'h6, 16'h0000);
    #1 check({15'h0000, hit}, 16'h0000);
    rd(3'h7, 16'h0004);
    $display("test disable done");
    give_verdict();
  end
endmodule
